// >>> hdl/excitation_injection_monitor.sv
// Excitation injection and stability monitor for a servo drive.
// Assumes a word-indexed parameter port, synchronous inputs, and a 50 MHz mclk.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Contract
// [RULE1] The excitation is refreshed every n drive samples, n from 1 to 255, reset value 2.
// [RULE2] Drive samples come at 16,000 Hz, so the refresh rate is 16,000 Hz over n.
// [RULE3] A sine frequency setting from 0 to 8,000 Hz, default 0, is held for the sine source.
// [RULE4] With current injection the current amplitude, default 0.2 A, is the peak amplitude.
// [RULE5] In mode 1 with current injection the amplitude sets the size added to the command.
// [RULE6] In mode 5 the time the current command stays above threshold is counted.
// [RULE7] When that time reaches the limit, fault 133 is raised.
// [RULE8] The limit is held in time units from 0.001 to 60.000 s, default 0.
// [RULE9] The threshold is held in current units from 0.001 A up to the peak, default 0; the code checks only the 0.001 A lower bound.
// [RULE10] The injection point is 0 none, 1 current, 2 velocity, default 0.
// [RULE11] Software should refresh the excitation no faster than it records data.
// [RULE12] Mode 0 off, 1 binary, 2 sine, 3 noise, 4 offset equal to the current amplitude.
// [RULE13] A nonzero watchdog forces the mode to 0 after its period; a nonzero rewrite restarts it.
// [RULE14] The above-threshold count clears when mode 5 is left or the command drops to threshold.
module excitation_injection_monitor
  import excite_pkg::*;
#(
  parameter int MS_CYCLES = CLOCK_HZ / MS_PER_S   // Clocks per millisecond.
) (
  input  wire logic        mclk,         // System clock, 50 MHz.
  input  wire logic        sys_rst,      // Asynchronous reset, high.
  input  wire logic [7:0]  reg_index,    // Parameter word index.
  input  wire logic        reg_write,    // Write strobe, one cycle.
  input  wire logic [31:0] reg_wdata,    // Write data.
  output logic      [31:0] reg_rdata,    // Read data, registered.
  input  wire logic [31:0] current_command,    // Current command magnitude, mA.
  input  wire logic signed [31:0] excite_sample, // Unit-scaled source sample.
  output logic signed [31:0] current_inject,   // Value added to current path.
  output logic signed [31:0] velocity_inject,  // Value added to velocity path.
  output logic             excite_refresh,     // Refresh pulse, one cycle.
  output logic      [31:0] sine_freq_out,      // Sine source frequency, Hz.
  output logic      [2:0]  mode_out,           // Active excitation mode.
  output logic             fault_active,       // Instability fault level.
  output logic      [31:0] fault_code          // Fault number while faulted.
);
  import excite_pkg::*;

  excite_cfg_if cfg ();

  logic [7:0]  gap_q, gap_d;
  logic [31:0] freq_q, freq_d, iamp_q, iamp_d, vamp_q, vamp_d;
  logic [1:0]  inj_q, inj_d;
  logic [2:0]  mode_q, mode_d;
  logic [31:0] lim_q, lim_d, thr_q, thr_d, wdp_q, wdp_d;
  logic [31:0] wdms_q, wdms_d, wdcyc_q, wdcyc_d;
  logic [31:0] rd_q, rd_d;
  logic signed [31:0] ci_q, ci_d, vi_q, vi_d;
  logic        ref_q, flt_q;
  logic [31:0] fc_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Parameter writes with range checks; out-of-range values are ignored, but a threshold above the peak amplitude is accepted.
  always_comb begin
    gap_d  = gap_q;
    freq_d = freq_q;
    iamp_d = iamp_q;
    vamp_d = vamp_q;
    inj_d  = inj_q;
    mode_d = mode_q;
    lim_d  = lim_q;
    thr_d  = thr_q;
    wdp_d  = wdp_q;
    if (reg_write) begin
      case (reg_index)
        IDX_UPDATE_INTERVAL:
          if (reg_wdata[7:0] >= INTERVAL_MIN && reg_wdata[31:8] == 24'h0) begin
            gap_d = reg_wdata[7:0]; // [RULE1]
          end
        IDX_SINE_FREQUENCY:
          if (reg_wdata <= SINE_FREQ_MAX) begin
            freq_d = reg_wdata; // [RULE3]
          end
        IDX_CURRENT_AMP:     iamp_d = reg_wdata; // [RULE4]
        IDX_VELOCITY_AMP:    vamp_d = reg_wdata;
        IDX_INJECT_POINT:
          if (reg_wdata <= 32'h2) begin
            inj_d = reg_wdata[1:0]; // [RULE10]
          end
        IDX_EXCITE_MODE:
          if (reg_wdata <= 32'h5) begin
            mode_d = reg_wdata[2:0]; // [RULE12]
          end
        IDX_TIME_LIMIT:
          if (reg_wdata >= 32'h1 && reg_wdata <= TIME_LIMIT_MAX) begin
            lim_d = reg_wdata; // [RULE8]
          end
        IDX_CURRENT_THRESH:
          if (reg_wdata >= 32'h1) begin
            thr_d = reg_wdata; // [RULE9]
          end
        IDX_WATCHDOG_PERIOD: wdp_d = reg_wdata;
        default: ;
      endcase
    end
    // Watchdog expiry turns the excitation off; a same-cycle mode write wins.
    if (wdp_q != 32'h0 && mode_q != 3'(MODE_OFF) && wdms_q >= wdp_q &&
        !(reg_write && reg_index == IDX_EXCITE_MODE)) begin
      mode_d = 3'(MODE_OFF); // [RULE13]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog millisecond timer, restarted by any mode write and held at zero while the mode is off.
  always_comb begin
    wdcyc_d = wdcyc_q;
    wdms_d  = wdms_q;
    if ((reg_write && reg_index == IDX_EXCITE_MODE) || mode_q == 3'(MODE_OFF)) begin
      wdcyc_d = 32'h0; // [RULE13]
      wdms_d  = 32'h0;
    end else if (wdcyc_q == 32'(MS_CYCLES - 1)) begin
      wdcyc_d = 32'h0;
      wdms_d  = wdms_q + 32'h1;
    end else begin
      wdcyc_d = wdcyc_q + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Injection: refreshed on each refresh pulse, routed by injection point.
  always_comb begin
    logic signed [31:0] amp_val;
    logic signed [31:0] shaped;
    amp_val = (inj_q == 2'(INJ_VELOCITY)) ? $signed(vamp_q) : $signed(iamp_q); // [RULE4]
    shaped  = 32'sh0;
    case (mode_q)
      3'(MODE_PRB):    shaped = excite_sample[31] ? -amp_val : amp_val; // [RULE5]
      3'(MODE_SINE),
      3'(MODE_NOISE):  shaped = 32'((64'(excite_sample) * 64'(amp_val)) >>> 15);
      3'(MODE_OFFSET): shaped = $signed(iamp_q);
      default:         shaped = 32'sh0;
    endcase
    ci_d = ci_q;
    vi_d = vi_q;
    if (mode_q == 3'(MODE_OFF) || inj_q == 2'(INJ_NONE)) begin
      ci_d = 32'sh0; // [RULE10]
      vi_d = 32'sh0;
    end else if (cfg.refresh) begin
      ci_d = (inj_q == 2'(INJ_CURRENT))  ? shaped : 32'sh0; // [RULE5]
      vi_d = (inj_q == 2'(INJ_VELOCITY)) ? shaped : 32'sh0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read-back of parameters and status.
  always_comb begin
    case (reg_index)
      IDX_UPDATE_INTERVAL: rd_d = {24'h0, gap_q};
      IDX_SINE_FREQUENCY:  rd_d = freq_q;
      IDX_CURRENT_AMP:     rd_d = iamp_q;
      IDX_VELOCITY_AMP:    rd_d = vamp_q;
      IDX_INJECT_POINT:    rd_d = {30'h0, inj_q};
      IDX_EXCITE_MODE:     rd_d = {29'h0, mode_q};
      IDX_TIME_LIMIT:      rd_d = lim_q;
      IDX_CURRENT_THRESH:  rd_d = thr_q;
      IDX_WATCHDOG_PERIOD: rd_d = wdp_q;
      IDX_STATUS:          rd_d = {30'h0, ref_q, cfg.fault};
      default:             rd_d = 32'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State registers.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      gap_q   <= RST_UPDATE_INTERVAL;
      freq_q  <= RST_SINE_FREQUENCY;
      iamp_q  <= RST_CURRENT_AMP;
      vamp_q  <= RST_ZERO;
      inj_q   <= 2'(INJ_NONE);
      mode_q  <= 3'(MODE_OFF);
      lim_q   <= RST_ZERO;
      thr_q   <= RST_ZERO;
      wdp_q   <= RST_ZERO;
      wdms_q  <= 32'h0;
      wdcyc_q <= 32'h0;
      rd_q    <= 32'h0;
      ci_q    <= 32'sh0;
      vi_q    <= 32'sh0;
      ref_q   <= 1'b0;
      flt_q   <= 1'b0;
      fc_q    <= 32'h0;
    end else begin
      gap_q   <= gap_d;
      freq_q  <= freq_d;
      iamp_q  <= iamp_d;
      vamp_q  <= vamp_d;
      inj_q   <= inj_d;
      mode_q  <= mode_d;
      lim_q   <= lim_d;
      thr_q   <= thr_d;
      wdp_q   <= wdp_d;
      wdms_q  <= wdms_d;
      wdcyc_q <= wdcyc_d;
      rd_q    <= rd_d;
      ci_q    <= ci_d;
      vi_q    <= vi_d;
      ref_q   <= cfg.refresh;
      flt_q   <= cfg.fault;
      fc_q    <= cfg.fault ? FAULT_INSTABILITY : 32'h0; // [RULE7]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers and outputs.
  assign cfg.interval       = gap_q;
  assign cfg.time_limit_ms  = lim_q;
  assign cfg.thresh_ma      = thr_q;
  assign cfg.stability_mode = (mode_q == 3'(MODE_STABILITY)); // [RULE6]

  excite_tick_gen u_tick (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .cfg     (cfg)
  );

  instability_monitor u_mon (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .cmd_ma  (current_command),
    .cfg     (cfg)
  );

  assign reg_rdata       = rd_q;
  assign current_inject  = ci_q;
  assign velocity_inject = vi_q;
  assign excite_refresh  = ref_q;
  assign sine_freq_out   = freq_q;
  assign mode_out        = mode_q;
  assign fault_active    = flt_q;
  assign fault_code      = fc_q; // [RULE7]

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_gap_range: assert property (@(posedge mclk) disable iff (sys_rst)
    gap_q >= INTERVAL_MIN) else $error("interval below one"); // [RULE1]
  a_freq_range: assert property (@(posedge mclk) disable iff (sys_rst)
    freq_q <= SINE_FREQ_MAX) else $error("sine frequency out of range"); // [RULE3]
  a_inj_none: assert property (@(posedge mclk) disable iff (sys_rst)
    inj_q == 2'(INJ_NONE) |=> ci_q == 0 && vi_q == 0) else $error("injection while none"); // [RULE10]
  a_offset_amp: assert property (@(posedge mclk) disable iff (sys_rst)
    (cfg.refresh && mode_q == 3'(MODE_OFFSET) && inj_q == 2'(INJ_CURRENT)
     && $stable(mode_q)) |=> ci_q == $signed($past(iamp_q))) else $error("offset wrong"); // [RULE12]
  a_wd_expiry: assert property (@(posedge mclk) disable iff (sys_rst)
    (wdp_q != 0 && mode_q != 0 && wdms_q >= wdp_q && !reg_write) |=> mode_q == 3'(MODE_OFF))
    else $error("watchdog did not stop mode"); // [RULE13]
  a_fault_code: assert property (@(posedge mclk) disable iff (sys_rst)
    fault_active |-> fault_code == FAULT_INSTABILITY) else $error("fault code wrong"); // [RULE7]
  c_refresh: cover property (@(posedge mclk) disable iff (sys_rst) excite_refresh);
  c_current_inj: cover property (@(posedge mclk) disable iff (sys_rst) ci_q != 0);
  c_wd_off: cover property (@(posedge mclk) disable iff (sys_rst) $fell(mode_q != 0));
endmodule : excitation_injection_monitor

// >>> hdl/excite_cfg_if.sv
// Interface carrying the configuration and tick between the top and its helpers.
// Assumes all parties share mclk.
`timescale 1ns/100ps
interface excite_cfg_if;
  logic [31:0] time_limit_ms;    // Instability limit in ms.
  logic [31:0] thresh_ma;        // Threshold in mA.
  logic        stability_mode;   // Mode 5 is active.
  logic        sample_tick;      // One pulse per drive sample.
  logic        fault;            // Instability fault level.
  logic [7:0]  interval;         // Samples between refreshes.
  logic        refresh;          // Excitation refresh pulse.

  modport top (output time_limit_ms, thresh_ma, stability_mode, interval,
               input sample_tick, fault, refresh);
  modport tick (input interval, output sample_tick, refresh);
  modport mon (input time_limit_ms, thresh_ma, stability_mode, sample_tick, output fault);
endinterface : excite_cfg_if

// >>> hdl/excite_pkg.sv
// Package for the excitation injection monitor: register map, reset values, codes, timing.
// Assumes one 50 MHz clock and a register port of word index, write strobe and data.
package excite_pkg;

  // Register indices as word numbers; byte address would be four times the index.
  localparam logic [7:0] IDX_UPDATE_INTERVAL = 8'h26;
  localparam logic [7:0] IDX_SINE_FREQUENCY  = 8'h28;
  localparam logic [7:0] IDX_CURRENT_AMP     = 8'h2a;
  localparam logic [7:0] IDX_INJECT_POINT    = 8'h2c;
  localparam logic [7:0] IDX_TIME_LIMIT      = 8'h30;
  localparam logic [7:0] IDX_CURRENT_THRESH  = 8'h32;
  localparam logic [7:0] IDX_EXCITE_MODE     = 8'h2e;
  localparam logic [7:0] IDX_WATCHDOG_PERIOD = 8'h34;
  localparam logic [7:0] IDX_VELOCITY_AMP    = 8'h36;
  localparam logic [7:0] IDX_STATUS          = 8'h38;

  // Reset values. Amplitude in mA, limit in ms, threshold in mA, frequency in Hz.
  localparam logic [7:0]  RST_UPDATE_INTERVAL = 8'h02;
  localparam logic [31:0] RST_SINE_FREQUENCY  = 32'h0000_0000;
  localparam logic [31:0] RST_CURRENT_AMP     = 32'h0000_00c8;
  localparam logic [31:0] RST_ZERO            = 32'h0000_0000;
  localparam logic [7:0]  INTERVAL_MIN        = 8'h01;
  localparam logic [31:0] SINE_FREQ_MAX       = 32'h0000_1f40;
  localparam logic [31:0] TIME_LIMIT_MAX      = 32'h0000_ea60;
  localparam logic [31:0] FAULT_INSTABILITY   = 32'h0000_0085;

  // Sample rate and clock rate; one drive sample is a whole number of clocks.
  localparam int CLOCK_HZ          = 50_000_000;
  localparam int SAMPLE_HZ         = 16_000;
  localparam int SAMPLE_CYCLES     = CLOCK_HZ / SAMPLE_HZ;
  localparam int MS_PER_S          = 1000;
  localparam int SAMPLES_PER_MS    = SAMPLE_HZ / MS_PER_S;

  // Mode and injection point codes.
  typedef enum logic [2:0] {
    MODE_OFF, MODE_PRB, MODE_SINE, MODE_NOISE, MODE_OFFSET, MODE_STABILITY
  } excite_mode_t;
  typedef enum logic [1:0] {INJ_NONE, INJ_CURRENT, INJ_VELOCITY} inject_point_t;

endpackage : excite_pkg

// >>> hdl/excite_tick_gen.sv
// Drive sample tick and excitation refresh pulse generator.
// Assumes mclk at 50 MHz and an interval of at least one sample.
`timescale 1ns/100ps
module excite_tick_gen
  import excite_pkg::*;
(
  input  wire logic mclk,       // System clock.
  input  wire logic sys_rst,    // Asynchronous reset, high.
  excite_cfg_if.tick cfg        // Interval in, ticks out.
);
  logic [15:0] div_q, div_d;
  logic [7:0]  gap_q, gap_d;
  logic        tick_q, tick_d, ref_q, ref_d;

  // Sample divider and refresh counter over samples.
  always_comb begin
    tick_d = 1'b0;
    ref_d  = 1'b0;
    div_d  = div_q + 16'h0001;
    gap_d  = gap_q;
    if (div_q == 16'(SAMPLE_CYCLES - 1)) begin
      div_d  = 16'h0000;
      tick_d = 1'b1; // [RULE2]
      if (gap_q + 8'h01 >= cfg.interval) begin
        gap_d = 8'h00;
        ref_d = 1'b1; // [RULE1]
      end else begin
        gap_d = gap_q + 8'h01;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      div_q  <= 16'h0000;
      gap_q  <= 8'h00;
      tick_q <= 1'b0;
      ref_q  <= 1'b0;
    end else begin
      div_q  <= div_d;
      gap_q  <= gap_d;
      tick_q <= tick_d;
      ref_q  <= ref_d;
    end
  end

  assign cfg.sample_tick = tick_q;
  assign cfg.refresh     = ref_q;

  a_refresh_on_tick: assert property (@(posedge mclk) disable iff (sys_rst)
    cfg.refresh |-> cfg.sample_tick) else $error("refresh without sample tick"); // [RULE1]
  a_tick_spacing: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(cfg.sample_tick) |=> !cfg.sample_tick[*8]) else $error("ticks too close"); // [RULE2]
endmodule : excite_tick_gen

// >>> hdl/instability_monitor.sv
// Times how long the current command stays above threshold in stability mode.
// Assumes the command is in mA and sample ticks come from the tick generator.
`timescale 1ns/100ps
module instability_monitor
  import excite_pkg::*;
(
  input  wire logic        mclk,       // System clock.
  input  wire logic        sys_rst,    // Asynchronous reset, high.
  input  wire logic [31:0] cmd_ma,     // Current command magnitude in mA.
  excite_cfg_if.mon        cfg         // Settings in, fault out.
);
  logic [31:0] cnt_q, cnt_d, lim_samples;
  logic        flt_q, flt_d, above;

  // Limit in ms becomes samples; a zero limit never trips.
  assign lim_samples = cfg.time_limit_ms * 32'(SAMPLES_PER_MS);
  assign above       = cmd_ma > cfg.thresh_ma;

  always_comb begin
    cnt_d = cnt_q;
    flt_d = flt_q;
    if (!cfg.stability_mode || !above) begin
      cnt_d = 32'h0000_0000; // [RULE14]
    end else if (cfg.sample_tick) begin
      cnt_d = cnt_q + 32'h0000_0001; // [RULE6]
    end
    if (cfg.stability_mode && lim_samples != 32'h0 && cnt_q >= lim_samples) begin
      flt_d = 1'b1; // [RULE7]
    end else if (!cfg.stability_mode) begin
      flt_d = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 32'h0000_0000;
      flt_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      flt_q <= flt_d;
    end
  end

  assign cfg.fault = flt_q;

  a_count_clears: assert property (@(posedge mclk) disable iff (sys_rst)
    (!cfg.stability_mode || !above) |=> cnt_q == 32'h0) else $error("count not cleared"); // [RULE14]
  a_fault_trips: assert property (@(posedge mclk) disable iff (sys_rst)
    (cfg.stability_mode && lim_samples != 0 && cnt_q >= lim_samples) |=> cfg.fault)
    else $error("fault not raised at limit"); // [RULE7]
  c_fault_seen: cover property (@(posedge mclk) disable iff (sys_rst) $rose(cfg.fault));
endmodule : instability_monitor

// >>> verification/testbench.sv
// Self-checking bench for the excitation injection monitor: registers, refresh, injection,
// watchdog and instability fault. Assumes the package, interface and design files are compiled.
`timescale 1ns/100ps
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); err_count++; end end

module testbench;
  import excite_pkg::*;

  localparam int MS_CYC       = 10;      // Short millisecond keeps the watchdog test brief.
  localparam int LIMIT_CYCLES = 95000;   // Ceiling for the whole run.

  logic               mclk;
  logic               sys_rst;
  logic        [7:0]  reg_index;
  logic               reg_write;
  logic        [31:0] reg_wdata;
  logic        [31:0] reg_rdata;
  logic        [31:0] current_command;
  logic signed [31:0] excite_sample;
  logic signed [31:0] current_inject;
  logic signed [31:0] velocity_inject;
  logic               excite_refresh;
  logic        [31:0] sine_freq_out;
  logic        [2:0]  mode_out;
  logic               fault_active;
  logic        [31:0] fault_code;
  int                 err_count;
  int                 samples_checked;
  int                 cycle_count;

  excitation_injection_monitor #(.MS_CYCLES(MS_CYC)) DUT (
    .mclk            (mclk),
    .sys_rst         (sys_rst),
    .reg_index       (reg_index),
    .reg_write       (reg_write),
    .reg_wdata       (reg_wdata),
    .reg_rdata       (reg_rdata),
    .current_command (current_command),
    .excite_sample   (excite_sample),
    .current_inject  (current_inject),
    .velocity_inject (velocity_inject),
    .excite_refresh  (excite_refresh),
    .sine_freq_out   (sine_freq_out),
    .mode_out        (mode_out),
    .fault_active    (fault_active),
    .fault_code      (fault_code)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard.
  always #10 mclk = ~mclk;

  // Counts cycles and cuts a hung run short as a failure.
  always @(posedge mclk) begin
    cycle_count++;
    if (cycle_count == LIMIT_CYCLES) begin
      err_count++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr_next

  // Expected injected value for a mode other than sine or noise, an amplitude and a source sample.
  function automatic logic signed [31:0] exp_inj(input logic [2:0] m, input logic [31:0] amp,
                                                 input logic signed [31:0] s);
    case (m)
      3'd4:    return $signed(amp);
      3'd1:    return (s < 0) ? -$signed(amp) : $signed(amp);
      default: return 32'sh0;
    endcase
  endfunction : exp_inj

  // One register write; the strobe drops before any following write.
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    @(posedge mclk);
    #1;
    reg_index = idx;
    reg_wdata = d;
    reg_write = 1'b1;
    @(posedge mclk);
    #1;
    reg_write = 1'b0;
  endtask : wr

  // Presents an index and compares the registered read one edge later.
  task automatic chk_reg(input logic [7:0] idx, input logic [31:0] exp);
    @(posedge mclk);
    #1;
    reg_index = idx;
    @(posedge mclk);
    #1;
    `CHECK(reg_rdata, exp)
  endtask : chk_reg

  // Waits for the next refresh pulse and returns the cycles waited.
  task automatic wait_refresh(output int n);
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (excite_refresh !== 1'b1 && n < 20000);
  endtask : wait_refresh

  task automatic stop_test();
    if (err_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    logic [31:0] rnd;
    logic [31:0] v;
    logic [31:0] f;
    logic [31:0] amp;
    int          n;
    mclk = 1'b0;
    sys_rst = 1'b1;
    reg_index = 8'h00;
    reg_write = 1'b0;
    reg_wdata = 32'h0;
    current_command = 32'h0;
    excite_sample = 32'sh0;
    err_count = 0;
    samples_checked = 0;
    cycle_count = 0;
    rnd = 32'h6000;
    repeat (10) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    // Reset values of the register table.
    chk_reg(IDX_UPDATE_INTERVAL, {24'h0, RST_UPDATE_INTERVAL});
    chk_reg(IDX_SINE_FREQUENCY, RST_SINE_FREQUENCY);
    chk_reg(IDX_CURRENT_AMP, RST_CURRENT_AMP);
    chk_reg(IDX_INJECT_POINT, RST_ZERO);
    chk_reg(IDX_TIME_LIMIT, RST_ZERO);
    chk_reg(IDX_CURRENT_THRESH, RST_ZERO);
    // Default refresh spacing is two samples.
    wait_refresh(n);
    wait_refresh(n);
    `CHECK(n, 2 * SAMPLE_CYCLES)
    // Random in-range settings read back; the frequency reaches the sine source.
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr_next(rnd);
      v = {30'h0, rnd[1:0]} + 32'h1;
      wr(IDX_UPDATE_INTERVAL, v);
      chk_reg(IDX_UPDATE_INTERVAL, v);
      rnd = lfsr_next(rnd);
      f = rnd % 32'd8001;
      wr(IDX_SINE_FREQUENCY, f);
      chk_reg(IDX_SINE_FREQUENCY, f);
      `CHECK(sine_freq_out, f)
    end
    // Boundary values accepted, out-of-range values ignored.
    wr(IDX_UPDATE_INTERVAL, 32'h0);
    chk_reg(IDX_UPDATE_INTERVAL, v);
    wr(IDX_UPDATE_INTERVAL, 32'h100);
    chk_reg(IDX_UPDATE_INTERVAL, v);
    wr(IDX_SINE_FREQUENCY, SINE_FREQ_MAX);
    wr(IDX_SINE_FREQUENCY, SINE_FREQ_MAX + 32'h1);
    chk_reg(IDX_SINE_FREQUENCY, SINE_FREQ_MAX);
    wr(IDX_INJECT_POINT, 32'h3);
    chk_reg(IDX_INJECT_POINT, RST_ZERO);
    wr(IDX_TIME_LIMIT, TIME_LIMIT_MAX);
    wr(IDX_TIME_LIMIT, TIME_LIMIT_MAX + 32'h1);
    chk_reg(IDX_TIME_LIMIT, TIME_LIMIT_MAX);
    wr(IDX_CURRENT_THRESH, 32'h1);
    wr(IDX_CURRENT_THRESH, 32'h0);
    chk_reg(IDX_CURRENT_THRESH, 32'h1);
    // Every mode code is taken; an undefined code is ignored.
    for (int m = 0; m < 7; m++) begin
      wr(IDX_EXCITE_MODE, 32'(m));
      repeat (2) @(posedge mclk);
      #1;
      `CHECK(mode_out, 3'((m > 5) ? 5 : m))
    end
    // Single-sample refresh spacing; two consecutive refreshes come one sample apart.
    wr(IDX_UPDATE_INTERVAL, 32'h1);
    wait_refresh(n);
    wait_refresh(n);
    `CHECK(n, SAMPLE_CYCLES)
    // Offset mode on the current path equals the amplitude.
    rnd = lfsr_next(rnd);
    amp = (rnd % 32'd4000) + 32'h1;
    wr(IDX_CURRENT_AMP, amp);
    wr(IDX_INJECT_POINT, 32'h1);
    wr(IDX_EXCITE_MODE, 32'h4);
    wait_refresh(n);
    `CHECK(current_inject, exp_inj(3'd4, amp, excite_sample))
    // Binary mode follows the sign of the source at full amplitude.
    wr(IDX_EXCITE_MODE, 32'h1);
    for (int k = 0; k < 2; k++) begin
      rnd = lfsr_next(rnd);
      excite_sample = (k == 0) ? $signed({17'h0, rnd[14:0]}) : -32'sd1000;
      wait_refresh(n);
      `CHECK(current_inject, exp_inj(3'd1, amp, excite_sample))
    end
    // Velocity point moves the excitation off the current path.
    wr(IDX_VELOCITY_AMP, 32'd500);
    wr(IDX_INJECT_POINT, 32'h2);
    chk_reg(IDX_VELOCITY_AMP, 32'd500);
    wait_refresh(n);
    `CHECK(current_inject, 32'sh0)
    `CHECK(velocity_inject, exp_inj(3'd1, 32'd500, excite_sample))
    // Point 0 and mode 0 zero the injection at once.
    wr(IDX_INJECT_POINT, 32'h0);
    repeat (3) @(posedge mclk);
    #1;
    `CHECK(velocity_inject, 32'sh0)
    wr(IDX_INJECT_POINT, 32'h1);
    wr(IDX_EXCITE_MODE, 32'h0);
    repeat (3) @(posedge mclk);
    #1;
    `CHECK(current_inject, 32'sh0)
    // Watchdog of one millisecond: a rewrite restarts it, then the mode drops to off.
    wr(IDX_WATCHDOG_PERIOD, 32'h1);
    wr(IDX_EXCITE_MODE, 32'h4);
    repeat (2) @(posedge mclk);
    #1;
    `CHECK(mode_out, 3'd4)
    repeat (3) @(posedge mclk);
    wr(IDX_EXCITE_MODE, 32'h4);
    repeat (7) @(posedge mclk);
    #1;
    `CHECK(mode_out, 3'd4)
    repeat (15) @(posedge mclk);
    #1;
    `CHECK(mode_out, 3'd0)
    wr(IDX_WATCHDOG_PERIOD, 32'h0);
    // Stability test: a 1 ms limit trips after 16 samples above threshold.
    wr(IDX_INJECT_POINT, 32'h0);
    wr(IDX_CURRENT_THRESH, 32'd1000);
    wr(IDX_TIME_LIMIT, 32'h1);
    current_command = 32'd1000 + {22'h0, rnd[9:0]} + 32'h1;
    wr(IDX_EXCITE_MODE, 32'h5);
    n = 0;
    while (fault_active !== 1'b1 && n < 60000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    `CHECK(n >= 15 * SAMPLE_CYCLES && n <= 17 * SAMPLE_CYCLES, 1'b1)
    `CHECK(fault_code, FAULT_INSTABILITY)
    // Leaving the stability mode clears the count and the fault.
    wr(IDX_EXCITE_MODE, 32'h0);
    repeat (3) @(posedge mclk);
    #1;
    `CHECK(fault_active, 1'b0)
    `CHECK(fault_code, RST_ZERO)
    stop_test();
  end

endmodule : testbench
